/* File: rtl/audio_dsp_config_bank.sv */
/*
 Configuration register bank for the audio processing chain, APB slave.
 Holds the two processing configuration registers and the enhancer
 configuration, decodes them into chain controls, applies ganged and
 locked volume, paces soft stepping and performs two-channel summation.
 Assumes one 10 MHz clock, APB master in the same domain, and that
 power, gain and threshold status inputs come from logic on this clock.
*/
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module audio_dsp_config_bank
   import dsp_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dsp_cfg_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Processing chain status
   input wire logic adc_powered,
   input wire logic [dsp_cfg_pkg::NUM_CH-1:0] channel_enhancer_enable,
   input wire logic [dsp_cfg_pkg::NUM_CH-1:0] gain_above_zero,
   input wire logic [dsp_cfg_pkg::NUM_CH-1:0] level_over_threshold,
   input wire logic [dsp_cfg_pkg::NUM_CH-1:0][dsp_cfg_pkg::VOL_W-1:0] digital_volume,
   // Sample path for summation
   input wire logic sample_valid,
   input wire logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] sample_ch1,
   input wire logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] sample_ch2,
   output logic sum_valid,
   output logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] sum_ch1,
   output logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] sum_ch2,
   // Decoded controls
   output dsp_cfg_pkg::dsp_ctrl_t dsp_ctrl,
   output logic [7:0] enhancer_config,
   output logic [dsp_cfg_pkg::NUM_CH-1:0] anti_clip_active,
   output logic [dsp_cfg_pkg::NUM_CH-1:0] compress_req,
   output logic [dsp_cfg_pkg::NUM_CH-1:0][dsp_cfg_pkg::VOL_W-1:0] applied_volume
);
   import dsp_cfg_pkg::*;

   typedef struct packed {
      cfg_zero_t cfg_zero;
      cfg_one_t cfg_one;
      logic [7:0] enhancer;
      logic [31:0] rdata;
      logic ready;
      logic slverr;
      dsp_ctrl_t ctrl;
      logic [STEP_CNT_W-1:0] step_cnt;
      logic tick;
      logic [NUM_CH-1:0][VOL_W-1:0] target;
      logic [NUM_CH-1:0] clip_active;
      logic [NUM_CH-1:0] compress;
   } bank_state_t;

   bank_state_t cur_ff;
   bank_state_t nxt_cur;

   localparam logic [STEP_CNT_W-1:0] STEP_LAST = STEP_CNT_W'(STEP_CYCLES - 1);

   // Byte address of a register index
   function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
      byte_addr = {idx, 2'b00};
   endfunction

   // Dynamics mode from compression, selection and channel enables
   function automatic dyn_mode_t pick_dyn(input cfg_one_t c, input logic any_enh);
      if (c.compression_enable) begin
         pick_dyn = DYN_COMPRESS;
      end else if (any_enh && c.enhancer_or_gainctl_select) begin
         pick_dyn = DYN_GAINCTL;
      end else if (any_enh) begin
         pick_dyn = DYN_ENHANCER;
      end else begin
         pick_dyn = DYN_OFF;
      end
   endfunction

   logic setup_phase;
   logic access_done;
   logic hit_zero;
   logic hit_one;
   logic hit_enh;
   logic addr_hit;
   logic wr_byte;
   logic vol_frozen;
   dyn_mode_t dyn_now;

   always_comb begin
      setup_phase = psel && !penable;
      access_done = psel && penable && cur_ff.ready;
      hit_zero = (paddr == byte_addr(IDX_CFG_ZERO));
      hit_one = (paddr == byte_addr(IDX_CFG_ONE));
      hit_enh = (paddr == byte_addr(IDX_ENHANCER));
      addr_hit = hit_zero || hit_one || hit_enh;
      // Only the low byte lane holds data; other lanes are ignored
      wr_byte = access_done && pwrite && pstrb[0];
      nxt_cur = cur_ff;

      // Zero wait state: ready rises for the access phase of every transfer
      nxt_cur.ready = setup_phase;
      nxt_cur.slverr = setup_phase && !addr_hit;
      nxt_cur.rdata = 32'h0000_0000;
      if (setup_phase && !pwrite) begin
         if (hit_zero) begin
            nxt_cur.rdata = {24'h00_0000, cur_ff.cfg_zero};
         end else if (hit_one) begin
            nxt_cur.rdata = {24'h00_0000, cur_ff.cfg_one};
         end else if (hit_enh) begin
            nxt_cur.rdata = {24'h00_0000, cur_ff.enhancer};
         end
      end

      if (wr_byte && hit_zero) begin
         nxt_cur.cfg_zero = pwdata[7:0];
      end
      if (wr_byte && hit_one) begin
         nxt_cur.cfg_one = pwdata[7:0];
      end
      if (wr_byte && hit_enh) begin
         nxt_cur.enhancer = pwdata[7:0];
      end

      // reserved decimation code holds last mode
      case (cur_ff.cfg_zero.decimation_response)
         DECIM_LINEAR: nxt_cur.ctrl.decimation = DECIM_LINEAR;
         DECIM_LOW_LAT: nxt_cur.ctrl.decimation = DECIM_LOW_LAT;
         DECIM_ULTRA_LOW: nxt_cur.ctrl.decimation = DECIM_ULTRA_LOW;
         default: nxt_cur.ctrl.decimation = cur_ff.ctrl.decimation;
      endcase

      nxt_cur.ctrl.sum_enable = (cur_ff.cfg_zero.channel_summation == SUM_AVERAGE);

      // code zero passes to programmable filter
      nxt_cur.ctrl.highpass = cur_ff.cfg_zero.highpass_select;

      nxt_cur.ctrl.biquads = cur_ff.cfg_one.biquad_count;

      nxt_cur.ctrl.soft_step_enable = !cur_ff.cfg_one.soft_step_disable;

      nxt_cur.ctrl.enhanced_algo = cur_ff.cfg_zero.enhanced_dynamics_algo;

      dyn_now = pick_dyn(cur_ff.cfg_one, |channel_enhancer_enable);
      nxt_cur.ctrl.dyn_mode = dyn_now;

      vol_frozen = cur_ff.cfg_zero.runtime_volume_lock && adc_powered;
      nxt_cur.ctrl.volume_locked = vol_frozen;
      nxt_cur.ctrl.volume_gang = cur_ff.cfg_one.volume_gang;

      if (!vol_frozen) begin
         for (int ch = 0; ch < NUM_CH; ch++) begin
            if (cur_ff.cfg_one.volume_gang) begin
               nxt_cur.target[ch] = digital_volume[0];
            end else begin
               nxt_cur.target[ch] = digital_volume[ch];
            end
         end
      end

      // Step pacing; a free-running tick keeps all channels in lockstep
      nxt_cur.tick = 1'b0;
      if (cur_ff.step_cnt == STEP_LAST) begin
         nxt_cur.step_cnt = '0;
         nxt_cur.tick = 1'b1;
      end else begin
         nxt_cur.step_cnt = cur_ff.step_cnt + 7'h01;
      end

      for (int ch = 0; ch < NUM_CH; ch++) begin
         nxt_cur.clip_active[ch] = cur_ff.cfg_one.anti_clip_enable
            && gain_above_zero[ch] && (dyn_now != DYN_OFF);
         nxt_cur.compress[ch] = nxt_cur.clip_active[ch] && level_over_threshold[ch];
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cur_ff <= '0;
         cur_ff.cfg_zero <= RST_CFG_ZERO;
         cur_ff.cfg_one <= RST_CFG_ONE;
         cur_ff.enhancer <= RST_ENHANCER;
         cur_ff.ctrl.decimation <= DECIM_LINEAR;
         cur_ff.ctrl.highpass <= HPF_CUT_00025;
         cur_ff.ctrl.biquads <= 2'h2;
         cur_ff.ctrl.soft_step_enable <= 1'b1;
         cur_ff.ctrl.dyn_mode <= DYN_OFF;
         cur_ff.target <= {NUM_CH{RST_VOLUME}};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_step
      volume_stepper u_step (
         .mclk(mclk),
         .nrst(nrst),
         .tick(cur_ff.tick),
         .bypass(!cur_ff.ctrl.soft_step_enable),
         .target(cur_ff.target[ch]),
         .volume(applied_volume[ch])
      );
   end

   // average of channel one and two
   channel_summer u_sum (
      .mclk(mclk),
      .nrst(nrst),
      .enable(cur_ff.ctrl.sum_enable),
      .in_valid(sample_valid),
      .in_a(sample_ch1),
      .in_b(sample_ch2),
      .out_valid(sum_valid),
      .out_a(sum_ch1),
      .out_b(sum_ch2)
   );

   assign prdata = cur_ff.rdata;
   assign pready = cur_ff.ready;
   assign pslverr = cur_ff.slverr;
   assign dsp_ctrl = cur_ff.ctrl;
   assign enhancer_config = cur_ff.enhancer;
   assign anti_clip_active = cur_ff.clip_active;
   assign compress_req = cur_ff.compress;
endmodule // audio_dsp_config_bank
`default_nettype wire

/* File: rtl/dsp_cfg_pkg.sv */
/*
 Shared constants and carriers for the audio processing configuration bank:
 register indices, reset values, field layouts, mode encodings and timing.
 Assumes a single 10 MHz clock domain and a 32-bit APB register port.
*/
package dsp_cfg_pkg;

   // Register indices; the APB byte address is four times the index
   localparam logic [7:0] IDX_CFG_ZERO = 8'h6B;
   localparam logic [7:0] IDX_CFG_ONE = 8'h6C;
   localparam logic [7:0] IDX_ENHANCER = 8'h6D;
   localparam int unsigned ADDR_W = 10;

   // Reset values
   localparam logic [7:0] RST_CFG_ZERO = 8'h01;
   localparam logic [7:0] RST_CFG_ONE = 8'h40;
   localparam logic [7:0] RST_ENHANCER = 8'h7B;
   localparam logic [7:0] RST_VOLUME = 8'hC9;

   // Channel and sample geometry
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned VOL_W = 8;
   localparam int unsigned SAMPLE_W = 24;

   // Volume step pacing
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned STEP_TIME_NS = 10000;
   localparam int unsigned STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned STEP_CNT_W = 7;

   // Field codes
   localparam logic [1:0] DECIM_LINEAR = 2'h0;
   localparam logic [1:0] DECIM_LOW_LAT = 2'h1;
   localparam logic [1:0] DECIM_ULTRA_LOW = 2'h2;
   localparam logic [1:0] SUM_OFF = 2'h0;
   localparam logic [1:0] SUM_AVERAGE = 2'h1;
   localparam logic [1:0] HPF_PROGRAMMABLE = 2'h0;
   localparam logic [1:0] HPF_CUT_00025 = 2'h1;
   localparam logic [1:0] HPF_CUT_0002 = 2'h2;
   localparam logic [1:0] HPF_CUT_0008 = 2'h3;

   // First processing configuration register, bit 7 down to bit 0
   typedef struct packed {
      logic runtime_volume_lock;
      logic enhanced_dynamics_algo;
      logic [1:0] decimation_response;
      logic [1:0] channel_summation;
      logic [1:0] highpass_select;
   } cfg_zero_t;

   // Second processing configuration register, bit 7 down to bit 0
   typedef struct packed {
      logic volume_gang;
      logic [1:0] biquad_count;
      logic soft_step_disable;
      logic enhancer_or_gainctl_select;
      logic reserved_bit;
      logic compression_enable;
      logic anti_clip_enable;
   } cfg_one_t;

   typedef enum logic [3:0] {
      DYN_OFF = 4'h1,
      DYN_ENHANCER = 4'h2,
      DYN_GAINCTL = 4'h4,
      DYN_COMPRESS = 4'h8
   } dyn_mode_t;

   // Decoded controls handed to the processing chain
   typedef struct packed {
      logic [1:0] decimation;
      logic sum_enable;
      logic [1:0] highpass;
      logic [1:0] biquads;
      logic soft_step_enable;
      dyn_mode_t dyn_mode;
      logic enhanced_algo;
      logic volume_locked;
      logic volume_gang;
   } dsp_ctrl_t;

endpackage

/* File: rtl/volume_stepper.sv */
/*
 One channel's applied digital volume, stepped one code per tick toward its
 target, or jumping straight to it when stepping is bypassed.
 Assumes the tick is a single-cycle pulse from the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module volume_stepper
   import dsp_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic tick,
   input wire logic bypass,
   input wire logic [dsp_cfg_pkg::VOL_W-1:0] target,
   output logic [dsp_cfg_pkg::VOL_W-1:0] volume
);
   typedef struct packed {
      logic [VOL_W-1:0] vol;
   } step_state_t;

   step_state_t cur_ff;
   step_state_t nxt_cur;

   always_comb begin
      nxt_cur = cur_ff;
      if (bypass) begin
         nxt_cur.vol = target;
      end else if (tick && cur_ff.vol < target) begin
         nxt_cur.vol = cur_ff.vol + 8'h01;
      end else if (tick && cur_ff.vol > target) begin
         nxt_cur.vol = cur_ff.vol - 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cur_ff <= '{vol: RST_VOLUME};
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign volume = cur_ff.vol;
endmodule // volume_stepper
`default_nettype wire

/* File: rtl/channel_summer.sv */
/*
 Two-channel summation stage: passes samples through, or replaces both with
 the average of the two when enabled. Registered, one cycle of latency.
 Assumes both samples arrive together with one valid strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module channel_summer
   import dsp_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic enable,
   input wire logic in_valid,
   input wire logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] in_a,
   input wire logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] in_b,
   output logic out_valid,
   output logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] out_a,
   output logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] out_b
);
   typedef struct packed {
      logic valid;
      logic [SAMPLE_W-1:0] a;
      logic [SAMPLE_W-1:0] b;
   } sum_state_t;

   sum_state_t cur_ff;
   sum_state_t nxt_cur;
   logic signed [SAMPLE_W:0] wide_sum;

   always_comb begin
      // One extra bit keeps the sum from wrapping before the halving
      wide_sum = {in_a[SAMPLE_W-1], in_a} + {in_b[SAMPLE_W-1], in_b};
      nxt_cur = cur_ff;
      nxt_cur.valid = in_valid;
      if (in_valid && enable) begin
         nxt_cur.a = wide_sum[SAMPLE_W:1];
         nxt_cur.b = wide_sum[SAMPLE_W:1];
      end else if (in_valid) begin
         nxt_cur.a = in_a;
         nxt_cur.b = in_b;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign out_valid = cur_ff.valid;
   assign out_a = cur_ff.a;
   assign out_b = cur_ff.b;
endmodule // channel_summer
`default_nettype wire

/* File: test/audio_dsp_config_bank_checker.sv */
/*
 Port assertions for the audio processing configuration bank.
 Assumes it is bound into audio_dsp_config_bank and shares its one clock.
*/
`timescale 1ns/1ns
`default_nettype none
module dsp_cfg_checker
   import dsp_cfg_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [dsp_cfg_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic adc_powered,
   input wire logic [dsp_cfg_pkg::NUM_CH-1:0] channel_enhancer_enable,
   input wire logic [dsp_cfg_pkg::NUM_CH-1:0][dsp_cfg_pkg::VOL_W-1:0] digital_volume,
   input wire logic sample_valid,
   input wire logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] sample_ch1,
   input wire logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] sample_ch2,
   input wire logic sum_valid,
   input wire logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] sum_ch1,
   input wire logic signed [dsp_cfg_pkg::SAMPLE_W-1:0] sum_ch2,
   input wire dsp_cfg_pkg::dsp_ctrl_t dsp_ctrl,
   input wire logic [dsp_cfg_pkg::NUM_CH-1:0][dsp_cfg_pkg::VOL_W-1:0] applied_volume
);
   logic wr0;
   logic wr1;
   logic signed [24:0] pair_sum;
   // Completed writes; controls follow two edges later
   assign wr0 = psel && penable && pready && pwrite && pstrb[0] && paddr == 10'h1AC;
   assign wr1 = psel && penable && pready && pwrite && pstrb[0] && paddr == 10'h1B0;
   assign pair_sum = sample_ch1 + sample_ch2;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);
   zero_fields_a: assert property (wr0 |-> ##2
      {dsp_ctrl.highpass, dsp_ctrl.enhanced_algo, dsp_ctrl.sum_enable} == {$past(pwdata[1:0], 2),
      $past(pwdata[6], 2), $past(pwdata[3:2], 2) == 2'h1}) else $error("cfg zero decode wrong");
   decim_code_a: assert property (wr0 && pwdata[5:4] != 2'h3 |-> ##2
      dsp_ctrl.decimation == $past(pwdata[5:4], 2)) else $error("decimation decode wrong");
   one_fields_a: assert property (wr1 |-> ##2
      {dsp_ctrl.biquads, dsp_ctrl.soft_step_enable, dsp_ctrl.volume_gang} == {$past(pwdata[6:5], 2),
      ~$past(pwdata[4], 2), $past(pwdata[7], 2)}) else $error("cfg one decode wrong");
   compress_mode_a: assert property (wr1 && pwdata[1] |-> ##2
      dsp_ctrl.dyn_mode == DYN_COMPRESS) else $error("compression not selected");
   dyn_select_a: assert property (wr1 && !pwdata[1] && (|channel_enhancer_enable) ##1
      (|channel_enhancer_enable) |=> dsp_ctrl.dyn_mode == ($past(pwdata[3], 2) ? DYN_GAINCTL :
      DYN_ENHANCER)) else $error("enhancer or gain mode wrong");
   sum_average_a: assert property (sample_valid && dsp_ctrl.sum_enable |=> sum_valid &&
      sum_ch1 == $past(pair_sum[24:1]) && sum_ch2 == sum_ch1) else $error("average wrong");
   gang_volume_a: assert property ((!dsp_ctrl.soft_step_enable && !adc_powered &&
      $stable(digital_volume) && $stable(dsp_ctrl))[*4] |-> applied_volume[1] ==
      (dsp_ctrl.volume_gang ? digital_volume[0] : digital_volume[1])) else $error("gang wrong");
   lock_hold_a: assert property ((dsp_ctrl.volume_locked && adc_powered &&
      !dsp_ctrl.soft_step_enable)[*3] |-> $stable(applied_volume)) else $error("lock ignored");
endmodule // dsp_cfg_checker
bind audio_dsp_config_bank dsp_cfg_checker i_chk (.mclk, .nrst, .psel, .penable, .pwrite, .paddr,
   .pwdata, .pstrb, .pready, .adc_powered, .channel_enhancer_enable, .digital_volume,
   .sample_valid, .sample_ch1, .sample_ch2, .sum_valid, .sum_ch1, .sum_ch2, .dsp_ctrl,
   .applied_volume);
`default_nettype wire

/* File: test/test_audio_dsp_config_bank.sv */
/*
 Self-checking bench for the configuration bank: APB traffic, summation, volume.
 Assumes the bound checker and a 10 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_audio_dsp_config_bank;
   import dsp_cfg_pkg::*;
   typedef struct packed {logic [31:0] d; logic e; logic c;} note_t;
   logic mclk, nrst, psel, penable, pwrite, pready, pslverr, adc_powered, sample_valid, sum_valid;
   logic [9:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] pstrb, en_in, gain_in, lvl_in, clip, cmp;
   logic signed [23:0] s1, s2, o1, o2;
   logic [3:0][7:0] vol, applied;
   logic [7:0] enh_cfg, prev, v;
   dsp_ctrl_t ctrl;
   note_t q[$];
   logic [47:0] sq[$];
   logic [7:0] m [3];
   int fails, comparisons, cyc;
   int seed = 32'h32A7F29B;
   audio_dsp_config_bank i_dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_powered(adc_powered),
      .channel_enhancer_enable(en_in), .gain_above_zero(gain_in), .level_over_threshold(lvl_in),
      .digital_volume(vol), .sample_valid(sample_valid), .sample_ch1(s1), .sample_ch2(s2),
      .sum_valid(sum_valid), .sum_ch1(o1), .sum_ch2(o2), .dsp_ctrl(ctrl),
      .enhancer_config(enh_cfg), .anti_clip_active(clip), .compress_req(cmp),
      .applied_volume(applied));
   initial begin
      mclk = 0;
      forever #50 mclk = ~mclk;
   end
   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      if (q.size() != 0 || sq.size() != 0) fails++;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // One APB transfer; the model notes what the answer must carry
   task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d,
         input logic [3:0] st, input logic err);
      int n;
      logic [1:0] k;
      k = a[3:2] - 2'h3;
      @(posedge mclk);
      q.push_back('{(w || err) ? 32'h0 : {24'h0, m[k]}, err, !w});
      if (w && st[0] && !err) m[k] = d;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pstrb <= st;
      pwdata <= {24'($random(seed)), d};
      @(posedge mclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (!pready && n < 20);
      psel <= 0;
      penable <= 0;
   endtask
   task automatic samp(input logic avg);
      logic signed [23:0] a, b;
      logic signed [24:0] t;
      a = 24'($random(seed));
      b = 24'($random(seed));
      t = a + b;
      @(posedge mclk);
      sq.push_back(avg ? {t[24:1], t[24:1]} : {a, b});
      sample_valid <= 1;
      s1 <= a;
      s2 <= b;
      @(posedge mclk);
      sample_valid <= 0;
   endtask
   always @(posedge mclk) begin
      note_t x;
      cyc++;
      if (psel && penable && pready) begin
         x = q.pop_front();
         check(pslverr, x.e);
         if (x.c) check(prdata, x.d);
      end
      if (sum_valid) check({o1, o2}, sq.pop_front());
      if (cyc == 4000) begin
         fails++;
         $display("unexpected at %0t: run too long", $time);
         final_report;
      end
   end
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, pstrb, adc_powered, sample_valid} = '0;
      {en_in, gain_in, lvl_in, vol, s1, s2} = '0;
      m[0] = 8'h01;
      m[1] = 8'h40;
      m[2] = 8'h7B;
      repeat (6) @(posedge mclk);
      nrst <= 1;
      for (int i = 0; i < 3; i++) apb(0, 10'h1AC + 10'(4 * i), 0, 4'h1, 0);
      apb(0, 10'h1B8, 0, 4'h1, 1);
      apb(1, 10'h000, 8'hFF, 4'h1, 1);
      $display("reset test done");
      en_in <= 4'hF;
      gain_in <= 4'($random(seed)) | 4'h1;
      lvl_in <= 4'($random(seed)) | 4'h1;
      for (int i = 0; i < 4; i++) begin
         apb(1, 10'h1AC, {4{2'(i)}}, 4'h1, 0);
         apb(1, 10'h1B0, {i[0], 2'(i), i[1], i[0], 1'b0, i[1] & i[0], i[0]}, 4'h1, 0);
         apb(0, 10'h1AC, 0, 4'h1, 0);
         apb(0, 10'h1B0, 0, 4'h1, 0);
      end
      for (int i = 0; i < 12; i++) begin
         v = 8'($random(seed));
         if (i % 3 == 1) v[2] = 1'b0;
         apb(1, 10'h1AC + 10'(4 * (i % 3)), v, 4'($random(seed)), 0);
         apb(0, 10'h1AC + 10'(4 * (i % 3)), 0, 4'h1, 0);
      end
      check(enh_cfg, m[2]);
      $display("register test done");
      apb(1, 10'h1AC, 8'h04, 4'h1, 0);
      repeat (3) @(posedge mclk);
      repeat (4) samp(1);
      apb(1, 10'h1AC, 8'h08, 4'h1, 0);
      repeat (3) @(posedge mclk);
      repeat (2) samp(0);
      $display("summation test done");
      vol <= $random(seed);
      apb(1, 10'h1B0, 8'hD0, 4'h1, 0);
      repeat (6) @(posedge mclk);
      check(applied[2], vol[0]);
      apb(1, 10'h1B0, 8'h50, 4'h1, 0);
      repeat (6) @(posedge mclk);
      check(applied[2], vol[2]);
      apb(1, 10'h1B0, 8'h51, 4'h1, 0);
      repeat (3) @(posedge mclk);
      check({clip, cmp}, {gain_in, gain_in & lvl_in});
      apb(1, 10'h1B0, 8'h50, 4'h1, 0);
      repeat (3) @(posedge mclk);
      check({clip, cmp}, 8'h00);
      // lock set by software before high rate use
      // Lock only bites while the converter is powered
      adc_powered <= 1;
      apb(1, 10'h1AC, 8'h80, 4'h1, 0);
      prev = vol[3];
      repeat (4) @(posedge mclk);
      vol[3] <= ~prev;
      repeat (6) @(posedge mclk);
      check(applied[3], prev);
      adc_powered <= 0;
      repeat (6) @(posedge mclk);
      check(applied[3], vol[3]);
      apb(1, 10'h1B0, 8'h40, 4'h1, 0);
      vol[1] <= vol[1] + 8'h10;
      repeat (150) @(posedge mclk);
      check(applied[1] !== vol[1], 1);
      $display("volume test done");
      final_report;
   end
endmodule // test_audio_dsp_config_bank
`default_nettype wire
